// file: opc_map.vh
// Register map, field positions, reset values and timing constants
`ifndef OPC_MAP_VH
`define OPC_MAP_VH
`define OPC_ADDR_FRAC_LOW     8'h03
`define OPC_ADDR_FRAC_MID     8'h04
`define OPC_ADDR_FRAC_HIGH    8'h05
`define OPC_ADDR_INT_PRE      8'h06
`define OPC_ADDR_POST_DIV     8'h07
`define OPC_ADDR_PWR_DOWN     8'h1e
`define OPC_ADDR_STATUS       8'h40
`define OPC_ADDR_SRC_SEL      8'h41
`define OPC_RST_FRAC_LOW      8'h21
`define OPC_RST_FRAC_MID      8'hfd
`define OPC_RST_FRAC_HIGH     6'h36
`define OPC_RST_INT           4'h7
`define OPC_RST_HALVER        1'b0
`define OPC_RST_POST_SEL      2'h2
`define OPC_RST_FRAC_EN       1'b1
`define OPC_RST_MCLK_HALVER   1'b0
`define OPC_RST_SLEEP         1'b1
`define OPC_BIT_OSC_SLEEP     3
`define OPC_BIT_SYNTH_SLEEP   0
`define OPC_BIT_HALVER        4
`define OPC_BIT_FRAC_EN       2
`define OPC_BIT_MCLK_HALVER   3
`define OPC_FRAC_BITS         22
`define OPC_DFLT_INT          4'h8
`define OPC_DFLT_FRAC         22'h00_0000
`define OPC_DFLT_POST_SEL     2'h2
`define OPC_SETTLE_NS         1000
`define OPC_CLK_NS            50
`define OPC_SETTLE_CYC        ((`OPC_SETTLE_NS + `OPC_CLK_NS - 1) / `OPC_CLK_NS)
`endif

// file: opc_settle.v
// Settle counter that flags synthesiser settings as not yet valid
`timescale 1ns/1ns
module opc_settle
(
	clk_sys,
	rst_n,
	restart,
	settled
);
`include "opc_map.vh"
	input  wire clk_sys;
	input  wire rst_n;
	input  wire restart;
	output reg  settled;

	// Count is small; cut to the counter width on purpose
	localparam integer SETTLE_INT = `OPC_SETTLE_CYC;
	localparam [5:0]   SETTLE_CYC = SETTLE_INT[5:0];
	reg [5:0] cnt_ff;

	always @(posedge clk_sys)
	begin
		if (!rst_n || restart)
		begin
			cnt_ff  <= 6'h00;
			settled <= 1'b0;
		end
		else if (cnt_ff != SETTLE_CYC)
		begin
			cnt_ff  <= cnt_ff + 6'h01;
			settled <= 1'b0;
		end
		else
			settled <= 1'b1;
	end
endmodule // opc_settle

// file: opc_clock_control.v
// Oscillator and synthesiser control with register port
// Behaviour
// R1: Keep oscillator on when synth/receiver used (not enforced: osc_sleep follows bit 3 at 1Eh alone)
// R2: Crystal clock selectable for master/aux pins
// R3: Bit 3 at 1Eh sleeps oscillator
// R4: Bit 0 at 1Eh sleeps synthesiser
// R5: Receiver enabled selects automatic mode
// R6: Receiver disabled uses software ratio fields
// R7: Automatic mode tracks recovered stream rate
// R8: Clocks kept but invalid until relock
// R9: Stream stop freezes ratio, holds frequency
// R10: Tolerate invalid frequency on stream removal
// R11: No stream in automatic: about 24MHz
// R12: Fraction split over 03h, 04h, 05h
// R13: Integer ratio bits 3:0 at 06h
// R14: Ratio is integer plus fraction over 2^22
// R15: Software computes integer and fraction parts
// R16: Software keeps integer ratio 5..13
// R17: Aim output 90-100MHz, integer 8
// R18: Bit 4 at 06h halves crystal clock
// R19: Bits 1:0 at 07h post-divider select
// R20: Automatic mode overrides post-divider select
// R21: Receiver needs specific ratio values
// R22: Software sets fraction enable with receiver
// R23: Synth asleep: clocks A and B inactive
// R24: Manual writes apply without power cycle
`timescale 1ns/1ns
module opc_clock_control
(
	clk_sys,
	rst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	rx_enable,
	rx_locked,
	rx_stream_present,
	rx_int_ratio,
	rx_frac_ratio,
	rx_post_sel,
	osc_sleep,
	crystal_clock_en,
	synth_sleep,
	synth_clock_en,
	synth_int_ratio,
	synth_frac_ratio,
	input_halver,
	post_divider_sel,
	fraction_enable,
	master_clock_halver,
	aux_clock_divider,
	master_src_sel,
	aux_src_sel,
	auto_mode,
	clocks_valid
);
`include "opc_map.vh"
	input  wire        clk_sys;
	input  wire        rst_n;
	input  wire [7:0]  reg_addr;
	input  wire [7:0]  reg_wdata;
	input  wire        reg_wr;
	input  wire        reg_rd;
	output reg  [7:0]  reg_rdata;
	input  wire        rx_enable;
	input  wire        rx_locked;
	input  wire        rx_stream_present;
	input  wire [3:0]  rx_int_ratio;
	input  wire [21:0] rx_frac_ratio;
	input  wire [1:0]  rx_post_sel;
	output reg         osc_sleep;
	output reg         crystal_clock_en;
	output reg         synth_sleep;
	output reg         synth_clock_en;
	output reg  [3:0]  synth_int_ratio;
	output reg  [21:0] synth_frac_ratio;
	output reg         input_halver;
	output reg  [1:0]  post_divider_sel;
	output reg         fraction_enable;
	output reg         master_clock_halver;
	output reg  [1:0]  aux_clock_divider;
	output reg  [1:0]  master_src_sel;
	output reg  [1:0]  aux_src_sel;
	output reg         auto_mode;
	output reg         clocks_valid;

	// Source codes for clock pin muxes
	localparam [1:0] SRC_SYNTH_A = 2'h0;
	localparam [1:0] SRC_SYNTH_B = 2'h1;
	localparam [1:0] SRC_CRYSTAL = 2'h2;

	// Automatic-mode states
	localparam [1:0] ST_DEFAULT  = 2'h0;
	localparam [1:0] ST_TRACK    = 2'h1;
	localparam [1:0] ST_HOLD     = 2'h2;

	reg [7:0]  frac_low_ff;
	reg [7:0]  frac_mid_ff;
	reg [5:0]  frac_high_ff;
	reg [3:0]  int_ratio_ff;
	reg        halver_ff;
	reg [1:0]  post_sel_ff;
	reg        frac_en_ff;
	reg        mclk_halver_ff;
	reg [1:0]  aux_div_ff;
	reg        osc_sleep_ff;
	reg        synth_sleep_ff;
	reg [1:0]  master_src_ff;
	reg [1:0]  aux_src_ff;
	reg [1:0]  state_ff;
	reg [1:0]  nxt_state;
	reg [3:0]  held_int_ff;
	reg [21:0] held_frac_ff;
	reg [1:0]  held_post_ff;
	reg        rx_enable_ff;
	reg        locked_ff;
	reg [3:0]  nxt_int;
	reg [21:0] nxt_frac;
	reg [1:0]  nxt_post;
	reg [7:0]  nxt_rdata;
	wire       settled;
	wire       restart;
	wire       cfg_write;

	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		input       wr;
		begin
			wr_hit = wr && (addr == target);
		end
	endfunction

	// A manual-mode settings write restarts the settle window, so clocks read invalid
	assign cfg_write = wr_hit(reg_addr, `OPC_ADDR_FRAC_LOW, reg_wr)
		|| wr_hit(reg_addr, `OPC_ADDR_FRAC_MID, reg_wr)
		|| wr_hit(reg_addr, `OPC_ADDR_FRAC_HIGH, reg_wr)
		|| wr_hit(reg_addr, `OPC_ADDR_INT_PRE, reg_wr)
		|| wr_hit(reg_addr, `OPC_ADDR_POST_DIV, reg_wr);
	assign restart = synth_sleep_ff || (rx_enable != rx_enable_ff)
		|| (cfg_write && !rx_enable);

	opc_settle u_settle
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.restart (restart),
		.settled (settled)
	);

	// Register file
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			frac_low_ff    <= `OPC_RST_FRAC_LOW;
			frac_mid_ff    <= `OPC_RST_FRAC_MID;
			frac_high_ff   <= `OPC_RST_FRAC_HIGH;
			int_ratio_ff   <= `OPC_RST_INT;
			halver_ff      <= `OPC_RST_HALVER;
			post_sel_ff    <= `OPC_RST_POST_SEL;
			frac_en_ff     <= `OPC_RST_FRAC_EN;
			mclk_halver_ff <= `OPC_RST_MCLK_HALVER;
			aux_div_ff     <= 2'h0;
			osc_sleep_ff   <= `OPC_RST_SLEEP;
			synth_sleep_ff <= `OPC_RST_SLEEP;
			master_src_ff  <= SRC_SYNTH_B;
			aux_src_ff     <= SRC_SYNTH_B;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`OPC_ADDR_FRAC_LOW:  frac_low_ff  <= reg_wdata; // [R12]
				`OPC_ADDR_FRAC_MID:  frac_mid_ff  <= reg_wdata; // [R12]
				`OPC_ADDR_FRAC_HIGH: frac_high_ff <= reg_wdata[5:0]; // [R12]
				`OPC_ADDR_INT_PRE:
				begin
					int_ratio_ff <= reg_wdata[3:0]; // [R13]
					halver_ff    <= reg_wdata[`OPC_BIT_HALVER]; // [R18]
				end
				`OPC_ADDR_POST_DIV:
				begin
					post_sel_ff    <= reg_wdata[1:0]; // [R19]
					frac_en_ff     <= reg_wdata[`OPC_BIT_FRAC_EN];
					mclk_halver_ff <= reg_wdata[`OPC_BIT_MCLK_HALVER];
					aux_div_ff     <= reg_wdata[5:4];
				end
				`OPC_ADDR_PWR_DOWN:
				begin
					osc_sleep_ff   <= reg_wdata[`OPC_BIT_OSC_SLEEP]; // [R3]
					synth_sleep_ff <= reg_wdata[`OPC_BIT_SYNTH_SLEEP]; // [R4]
				end
				`OPC_ADDR_SRC_SEL:
				begin
					master_src_ff <= reg_wdata[1:0]; // [R2]
					aux_src_ff    <= reg_wdata[5:4]; // [R2]
				end
				default:
					osc_sleep_ff <= osc_sleep_ff;
			endcase
		end
	end

	// Automatic-mode tracking, hold and default
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_DEFAULT:
				if (rx_stream_present)
					nxt_state = ST_TRACK; // [R7]
			ST_TRACK:
				if (!rx_stream_present)
					nxt_state = ST_HOLD; // [R9]
			ST_HOLD:
				if (rx_stream_present)
					nxt_state = ST_TRACK;
			default:
				nxt_state = ST_DEFAULT;
		endcase
		if (!rx_enable)
			nxt_state = ST_DEFAULT;
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_ff     <= ST_DEFAULT;
			held_int_ff  <= `OPC_DFLT_INT;
			held_frac_ff <= `OPC_DFLT_FRAC;
			held_post_ff <= `OPC_DFLT_POST_SEL;
			rx_enable_ff <= 1'b0;
			locked_ff    <= 1'b0;
		end
		else
		begin
			state_ff     <= nxt_state;
			rx_enable_ff <= rx_enable;
			locked_ff    <= rx_locked;
			if (!rx_enable)
			begin
				// Back to the free-running default for the next stream
				held_int_ff  <= `OPC_DFLT_INT; // [R11]
				held_frac_ff <= `OPC_DFLT_FRAC; // [R11]
				held_post_ff <= `OPC_DFLT_POST_SEL;
			end
			else if (rx_stream_present)
			begin
				// Glitches on removal are tracked as-is; relock clears them
				held_int_ff  <= rx_int_ratio; // [R7] [R10]
				held_frac_ff <= rx_frac_ratio; // [R7] [R10]
				held_post_ff <= rx_post_sel;
			end
		end
	end

	// Settings mux: receiver in automatic mode, registers in manual
	always @*
	begin
		if (rx_enable)
		begin
			nxt_int  = held_int_ff; // [R5] [R9]
			nxt_frac = held_frac_ff; // [R5] [R9]
			nxt_post = held_post_ff; // [R20]
		end
		else
		begin
			nxt_int  = int_ratio_ff; // [R6] [R24]
			nxt_frac = {frac_high_ff, frac_mid_ff, frac_low_ff}; // [R6] [R14]
			nxt_post = post_sel_ff; // [R6] [R24]
		end
	end

	// Read mux
	always @*
	begin
		nxt_rdata = 8'h00;
		case (reg_addr)
			`OPC_ADDR_FRAC_LOW:  nxt_rdata = frac_low_ff;
			`OPC_ADDR_FRAC_MID:  nxt_rdata = frac_mid_ff;
			`OPC_ADDR_FRAC_HIGH: nxt_rdata = {2'h0, frac_high_ff};
			`OPC_ADDR_INT_PRE:   nxt_rdata = {3'h0, halver_ff, int_ratio_ff};
			`OPC_ADDR_POST_DIV:
				nxt_rdata = {2'h0, aux_div_ff, mclk_halver_ff, frac_en_ff,
					post_sel_ff};
			`OPC_ADDR_PWR_DOWN:
				nxt_rdata = {4'h0, osc_sleep_ff, 2'h0, synth_sleep_ff};
			`OPC_ADDR_STATUS:
				nxt_rdata = {3'h0, clocks_valid, locked_ff, state_ff,
					auto_mode};
			`OPC_ADDR_SRC_SEL:
				nxt_rdata = {2'h0, aux_src_ff, 2'h0, master_src_ff};
			default:
				nxt_rdata = 8'h00;
		endcase
	end

	// Registered outputs
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			reg_rdata           <= 8'h00;
			osc_sleep           <= `OPC_RST_SLEEP;
			crystal_clock_en    <= 1'b0;
			synth_sleep         <= `OPC_RST_SLEEP;
			synth_clock_en      <= 1'b0;
			synth_int_ratio     <= `OPC_RST_INT;
			synth_frac_ratio    <= {`OPC_RST_FRAC_HIGH, `OPC_RST_FRAC_MID,
				`OPC_RST_FRAC_LOW};
			input_halver        <= `OPC_RST_HALVER;
			post_divider_sel    <= `OPC_RST_POST_SEL;
			fraction_enable     <= `OPC_RST_FRAC_EN;
			master_clock_halver <= `OPC_RST_MCLK_HALVER;
			aux_clock_divider   <= 2'h0;
			master_src_sel      <= SRC_SYNTH_B;
			aux_src_sel         <= SRC_SYNTH_B;
			auto_mode           <= 1'b0;
			clocks_valid        <= 1'b0;
		end
		else
		begin
			reg_rdata           <= reg_rd ? nxt_rdata : 8'h00;
			osc_sleep           <= osc_sleep_ff; // [R3]
			crystal_clock_en    <= !osc_sleep_ff; // [R3] [R1]
			synth_sleep         <= synth_sleep_ff; // [R4]
			// Gated on a flop so no glitch reaches downstream muxes
			synth_clock_en      <= !synth_sleep_ff; // [R23]
			synth_int_ratio     <= nxt_int;
			synth_frac_ratio    <= nxt_frac;
			input_halver        <= halver_ff; // [R18]
			post_divider_sel    <= nxt_post; // [R19] [R20]
			fraction_enable     <= frac_en_ff; // [R22]
			master_clock_halver <= mclk_halver_ff;
			aux_clock_divider   <= aux_div_ff;
			master_src_sel      <= master_src_ff; // [R2]
			aux_src_sel         <= aux_src_ff; // [R2]
			auto_mode           <= rx_enable; // [R5]
			// Clocks keep running unless the synth sleeps; otherwise only the valid flag drops
			clocks_valid        <= settled && !synth_sleep_ff
				&& (!rx_enable || (rx_locked && state_ff == ST_TRACK)); // [R8]
		end
	end
endmodule // opc_clock_control

// file: opc_clock_control_sva.sv
// Port-level checks for the clock control block
`timescale 1ns/1ns
module opc_clock_control_sva
(
	input wire        clk_sys,
	input wire        rst_n,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        rx_enable,
	input wire        rx_locked,
	input wire        rx_stream_present,
	input wire [3:0]  rx_int_ratio,
	input wire [1:0]  rx_post_sel,
	input wire        osc_sleep,
	input wire        crystal_clock_en,
	input wire        synth_sleep,
	input wire        synth_clock_en,
	input wire [3:0]  synth_int_ratio,
	input wire [21:0] synth_frac_ratio,
	input wire        input_halver,
	input wire [1:0]  post_divider_sel,
	input wire        auto_mode,
	input wire        clocks_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Manual-mode write, mode steady until the output flop loads
	sequence s_man_wr(a);
		reg_wr && reg_addr == a && !rx_enable && !auto_mode ##1 !rx_enable;
	endsequence
	sequence s_auto_idle;
		auto_mode && rx_enable && !rx_stream_present;
	endsequence
	AST_CRYSTAL_EN:
	assert property (crystal_clock_en == !osc_sleep) else $error("crystal en");
	AST_OSC_WR:
	assert property (reg_wr && reg_addr == 8'h1e |->
		##2 osc_sleep == $past(reg_wdata[3], 2)) else $error("osc sleep");
	AST_SYN_GATE:
	assert property (synth_sleep |-> !synth_clock_en) else $error("synth gate");
	AST_AUTO:
	assert property ($past(rst_n) |-> auto_mode == $past(rx_enable))
		else $error("auto mode");
	AST_INT_WR:
	assert property (s_man_wr(8'h06) |-> ##1
		synth_int_ratio == $past(reg_wdata[3:0], 2) &&
		input_halver == $past(reg_wdata[4], 2)) else $error("int write");
	AST_FRAC_WR:
	assert property (s_man_wr(8'h03) |-> ##1
		synth_frac_ratio[7:0] == $past(reg_wdata, 2)) else $error("frac");
	AST_TRACK:
	assert property ((auto_mode && rx_stream_present && $stable(rx_post_sel)
		&& $stable(rx_int_ratio))[*5] |-> post_divider_sel == rx_post_sel &&
		synth_int_ratio == rx_int_ratio) else $error("tracking");
	AST_HOLD:
	assert property (s_auto_idle[*4] |=> $stable(synth_int_ratio) &&
		$stable(synth_frac_ratio)) else $error("hold");
	AST_UNLOCK:
	assert property (auto_mode && !rx_locked && !$past(rx_locked) |->
		!clocks_valid) else $error("valid unlocked");
endmodule // opc_clock_control_sva

// file: opc_rx_model.sv
// Behavioural receiver driving the automatic-mode settings
`timescale 1ns/1ns
module opc_rx_model
(
	input  wire        clk_sys,
	input  wire        stream_on,
	output reg         rx_stream_present,
	output reg         rx_locked,
	output reg  [3:0]  rx_int_ratio,
	output reg  [21:0] rx_frac_ratio,
	output reg  [1:0]  rx_post_sel
);
	reg [3:0] lock_cnt_ff;
	initial
	begin
		{rx_stream_present, rx_locked, lock_cnt_ff} = 6'h00;
		{rx_int_ratio, rx_frac_ratio, rx_post_sel} = 28'h000_0000;
	end
	always @(posedge clk_sys)
	begin
		rx_stream_present <= stream_on;
		rx_locked <= stream_on && lock_cnt_ff == 4'h8;
		if (stream_on)
		begin
			rx_int_ratio <= 4'h7;
			rx_frac_ratio <= 22'h21_b089;
			rx_post_sel <= 2'h1;
			if (lock_cnt_ff != 4'h8)
				lock_cnt_ff <= lock_cnt_ff + 4'h1;
		end
		else
		begin
			// Junk when idle, so a device that fails to freeze shows it
			rx_int_ratio <= ~rx_int_ratio;
			rx_frac_ratio <= ~rx_frac_ratio;
			rx_post_sel <= ~rx_post_sel;
			lock_cnt_ff <= 4'h0;
		end
	end
endmodule // opc_rx_model

// file: opc_clock_control_tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ns
module opc_clock_control_tb;
	reg         clk_sys, rst_n, reg_wr, reg_rd, rx_enable, stream_on;
	reg  [7:0]  reg_addr, reg_wdata;
	wire [7:0]  reg_rdata;
	wire [3:0]  rx_int_ratio, synth_int_ratio;
	wire [21:0] rx_frac_ratio, synth_frac_ratio;
	wire [1:0]  rx_post_sel, post_divider_sel, master_src_sel, aux_src_sel;
	wire        rx_locked, rx_stream_present, osc_sleep, crystal_clock_en;
	wire        synth_sleep, synth_clock_en, input_halver, auto_mode;
	wire        clocks_valid;
	wire        fraction_enable, master_clock_halver;
	wire [1:0]  aux_clock_divider;
	integer     fail_count = 0;
	integer     tests_run = 0;
	opc_clock_control u_opc_clock_control (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_enable(rx_enable),
		.rx_locked(rx_locked), .rx_stream_present(rx_stream_present),
		.rx_int_ratio(rx_int_ratio), .rx_frac_ratio(rx_frac_ratio),
		.rx_post_sel(rx_post_sel), .osc_sleep(osc_sleep),
		.crystal_clock_en(crystal_clock_en), .synth_sleep(synth_sleep),
		.synth_clock_en(synth_clock_en), .synth_int_ratio(synth_int_ratio),
		.synth_frac_ratio(synth_frac_ratio), .input_halver(input_halver),
		.post_divider_sel(post_divider_sel),
		.fraction_enable(fraction_enable),
		.master_clock_halver(master_clock_halver),
		.aux_clock_divider(aux_clock_divider),
		.master_src_sel(master_src_sel), .aux_src_sel(aux_src_sel),
		.auto_mode(auto_mode), .clocks_valid(clocks_valid));
	opc_rx_model u_opc_rx_model (.clk_sys(clk_sys), .stream_on(stream_on),
		.rx_stream_present(rx_stream_present), .rx_locked(rx_locked),
		.rx_int_ratio(rx_int_ratio), .rx_frac_ratio(rx_frac_ratio),
		.rx_post_sel(rx_post_sel));
	always #25 clk_sys = ~clk_sys;
	task chk(input [31:0] got, input [31:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task cyc(input integer n);
	begin
		repeat (n) @(posedge clk_sys);
		#1;
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [7:0] m, input [7:0] e);
	begin
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	end
	endtask
	// Restart settling can take a while, so poll with a bound
	task wait_valid(input e);
		integer i;
	begin
		for (i = 0; i < 40 && clocks_valid !== e; i = i + 1)
			cyc(1);
		chk(clocks_valid, e);
	end
	endtask
	task t_reset;
	begin
		rd(8'h03, 8'hff, 8'h21);
		rd(8'h04, 8'hff, 8'hfd);
		rd(8'h05, 8'h3f, 8'h36);
		rd(8'h06, 8'h1f, 8'h07);
		rd(8'h07, 8'h03, 8'h02);
		rd(8'h1e, 8'h09, 8'h09);
		rd(8'h20, 8'hff, 8'h00);
		chk({synth_int_ratio, synth_frac_ratio}, 26'h1f6_fd21);
		chk({osc_sleep, crystal_clock_en, synth_sleep, synth_clock_en},
			4'ha);
		chk({master_src_sel, aux_src_sel}, 4'h5);
	end
	endtask
	task t_power;
	begin
		wr(8'h1e, 8'h00);
		cyc(2);
		chk({osc_sleep, crystal_clock_en, synth_sleep, synth_clock_en},
			4'h5);
		wait_valid(1'b1);
		wr(8'h1e, 8'h01);
		cyc(3);
		chk({synth_sleep, synth_clock_en, clocks_valid}, 3'h4);
		wr(8'h1e, 8'h00);
	end
	endtask
	task t_manual;
	begin
		wr(8'h06, 8'h18);
		wr(8'h07, 8'h2d);
		wr(8'h03, 8'hba);
		wr(8'h04, 8'h49);
		wr(8'h05, 8'h0c);
		wr(8'h20, 8'hff);
		wr(8'h41, 8'h22);
		cyc(2);
		chk({synth_int_ratio, synth_frac_ratio}, 26'h20c_49ba);
		chk({input_halver, post_divider_sel}, 3'h5);
		chk({master_src_sel, aux_src_sel}, 4'ha);
		chk({fraction_enable, master_clock_halver, aux_clock_divider},
			4'he);
		chk(clocks_valid, 1'b0);
		wait_valid(1'b1);
		rd(8'h03, 8'hff, 8'hba);
	end
	endtask
	task t_auto;
	begin
		@(posedge clk_sys);
		rx_enable <= 1'b1;
		cyc(6);
		chk({auto_mode, synth_int_ratio, synth_frac_ratio, post_divider_sel},
			29'h1800_0002);
		chk(clocks_valid, 1'b0);
		@(posedge clk_sys);
		stream_on <= 1'b1;
		cyc(6);
		chk({synth_int_ratio, synth_frac_ratio, post_divider_sel},
			28'h786_c225);
		wr(8'h07, 8'h06);
		cyc(2);
		chk(post_divider_sel, 2'h1);
		wait_valid(1'b1);
		rd(8'h40, 8'hff, 8'h1b);
		@(posedge clk_sys);
		stream_on <= 1'b0;
		cyc(6);
		chk({synth_int_ratio, synth_frac_ratio}, 26'h1e1_b089);
		@(posedge clk_sys);
		rx_enable <= 1'b0;
		cyc(4);
		chk({auto_mode, synth_int_ratio, post_divider_sel}, 7'h22);
	end
	endtask
	task wrap_up;
	begin
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	initial
	begin
		{clk_sys, rst_n, reg_wr, reg_rd, rx_enable, stream_on} = 6'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_power;
		t_manual;
		t_auto;
		wrap_up;
	end
	initial
	begin
		#100000;
		fail_count = fail_count + 1;
		wrap_up;
	end
endmodule // opc_clock_control_tb
bind opc_clock_control opc_clock_control_sva u_opc_clock_control_sva (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .rx_enable(rx_enable),
	.rx_locked(rx_locked), .rx_stream_present(rx_stream_present),
	.rx_int_ratio(rx_int_ratio), .rx_post_sel(rx_post_sel),
	.osc_sleep(osc_sleep), .crystal_clock_en(crystal_clock_en),
	.synth_sleep(synth_sleep), .synth_clock_en(synth_clock_en),
	.synth_int_ratio(synth_int_ratio), .synth_frac_ratio(synth_frac_ratio),
	.input_halver(input_halver), .post_divider_sel(post_divider_sel),
	.auto_mode(auto_mode), .clocks_valid(clocks_valid));
